/* File: umic_top.sv */
// manchester/irda/smart-card configuration and status block, apb slave
// Functional notes
// - error count totals smart-card errors and clears on each read
// - transmit preamble length zero sends no preamble
// - transmit preamble length 1..15 sends that many bit periods
// - transmit pattern field picks ones, zeros, rise or fall pairs
// - polarity clear: zero rises, one falls; set swaps both codings
// - receive preamble length zero disables preamble detection
// - receive preamble length 1..15 expects that many bit periods
// - receive pattern field picks the expected preamble pattern
// - drift bit set lets the receiver track clock drift
// - drift bit clear means no tracking of clock drift
// - infrared filter value sets the demodulator glitch filter
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module umic_top (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // smart-card error events
    input  wire logic        sc_char_err,
    // transmit side
    input  wire logic        half_tick,
    input  wire logic        tx_frame_req,
    input  wire logic        tx_data_bit,
    output logic             tx_data_take,
    output logic             man_txd,
    output logic             tx_busy,
    // receive side
    input  wire logic        os_tick,
    input  wire logic        rx_enable,
    input  wire logic        ir_mode,
    input  wire logic        man_rxd,
    input  wire logic        ir_rxd,
    output logic             rx_bit_valid,
    output logic             rx_bit,
    output logic             rx_frame_open,
    // interrupt
    output logic             irq
);
    logic [31:0]              man_q;
    logic [7:0]               ifilt_q;
    logic [7:0]               err_q;
    logic [umic_pkg::ST_W-1:0] stat_q;
    logic [umic_pkg::ST_W-1:0] mask_q;
    logic [umic_pkg::ST_W-1:0] ev;
    logic [31:0]              rdata_d;
    logic [31:0]              prdata_q;
    logic                     ack_q;
    logic                     err_d;
    logic                     err_resp_q;
    logic                     access;
    logic                     capture;
    logic                     wr_en;
    logic                     rd_ner;
    logic [7:0]               flt_cnt_q;
    logic                     ir_filt_q;
    logic                     rx_line;
    logic                     pre_ok;
    logic                     pre_err;

    umic_man_if cfg_if ();

    // apb handshake: one wait cycle so read data comes from a flop
    assign access  = psel && penable;
    assign capture = access && !ack_q;
    assign pready  = access && ack_q;
    assign pslverr = pready && err_resp_q;
    assign prdata  = prdata_q;
    assign wr_en   = pready && pwrite;
    assign rd_ner  = capture && !pwrite && paddr == umic_pkg::OFF_NER;

    always_comb begin
        rdata_d = 32'h0000_0000;
        err_d   = 1'b0;
        if (paddr == umic_pkg::OFF_NER) begin
            rdata_d[7:0] = err_q;
        end else if (paddr == umic_pkg::OFF_MAN) begin
            rdata_d = man_q;
        end else if (paddr == umic_pkg::OFF_IF) begin
            rdata_d[7:0] = ifilt_q;
        end else if (paddr == umic_pkg::OFF_STAT) begin
            rdata_d[umic_pkg::ST_W-1:0] = stat_q;
        end else if (paddr == umic_pkg::OFF_MASK) begin
            rdata_d[umic_pkg::ST_W-1:0] = mask_q;
        end else begin
            err_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_q      <= 1'b0;
            prdata_q   <= 32'h0000_0000;
            err_resp_q <= 1'b0;
        end else begin
            ack_q <= capture;
            if (capture) begin
                prdata_q   <= pwrite ? 32'h0000_0000 : rdata_d;
                err_resp_q <= err_d;
            end
        end
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            man_q   <= umic_pkg::MAN_RST;
            ifilt_q <= umic_pkg::IF_RST;
            mask_q  <= umic_pkg::MASK_RST;
        end else if (wr_en) begin
            if (paddr == umic_pkg::OFF_MAN) begin
                man_q <= pwdata & umic_pkg::MAN_RW_MASK;
            end else if (paddr == umic_pkg::OFF_IF) begin
                ifilt_q <= pwdata[7:0];
            end else if (paddr == umic_pkg::OFF_MASK) begin
                mask_q <= pwdata[umic_pkg::ST_W-1:0];
            end
        end
    end

    assign cfg_if.tx_len = man_q[umic_pkg::TXPL_LSB +: 4];
    assign cfg_if.tx_sel = man_q[umic_pkg::TXPP_LSB +: 2];
    assign cfg_if.tx_pol = man_q[umic_pkg::TXPOL_BIT];
    assign cfg_if.rx_len = man_q[umic_pkg::RXPL_LSB +: 4];
    assign cfg_if.rx_sel = man_q[umic_pkg::RXPP_LSB +: 2];
    assign cfg_if.rx_pol = man_q[umic_pkg::RXPOL_BIT];
    // only meaningful with 16x oversampling ticks on os_tick
    assign cfg_if.drift  = man_q[umic_pkg::DRIFT_BIT];

    // error counter; a new error in the clearing cycle is kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_q <= 8'h00;
        end else if (sc_char_err) begin
            if (rd_ner) begin
                err_q <= 8'h01;
            end else if (err_q != umic_pkg::ERR_MAX) begin
                err_q <= err_q + 8'h01;
            end
        end else if (rd_ner) begin
            err_q <= 8'h00;
        end
    end

    // infrared glitch filter: a level must hold filter+1 cycles to pass
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flt_cnt_q <= 8'h00;
            ir_filt_q <= 1'b1;
        end else if (ir_rxd == ir_filt_q) begin
            flt_cnt_q <= 8'h00;
        end else if (flt_cnt_q >= ifilt_q) begin
            ir_filt_q <= ir_rxd;
            flt_cnt_q <= 8'h00;
        end else begin
            flt_cnt_q <= flt_cnt_q + 8'h01;
        end
    end

    assign rx_line = ir_mode ? ir_filt_q : man_rxd;

    umic_man_tx u_tx (
        .pclk      (pclk),
        .presetn   (presetn),
        .cfg       (cfg_if.tx),
        .half_tick (half_tick),
        .frame_req (tx_frame_req),
        .data_bit  (tx_data_bit),
        .data_take (tx_data_take),
        .txd       (man_txd),
        .busy      (tx_busy)
    );

    umic_man_rx u_rx (
        .pclk       (pclk),
        .presetn    (presetn),
        .cfg        (cfg_if.rx),
        .os_tick    (os_tick),
        .rx_en      (rx_enable),
        .rxd        (rx_line),
        .bit_valid  (rx_bit_valid),
        .bit_val    (rx_bit),
        .pre_ok     (pre_ok),
        .pre_err    (pre_err),
        .frame_open (rx_frame_open)
    );

    // sticky status, write one to clear; a set in the same cycle wins
    always_comb begin
        ev = '0;
        ev[umic_pkg::ST_PRE_OK]  = pre_ok;
        ev[umic_pkg::ST_PRE_ERR] = pre_err;
        ev[umic_pkg::ST_SC_ERR]  = sc_char_err;
        ev[umic_pkg::ST_SAT]     = sc_char_err
                                   && err_q == umic_pkg::ERR_MAX;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= '0;
        end else if (wr_en && paddr == umic_pkg::OFF_STAT) begin
            stat_q <= (stat_q & ~pwdata[umic_pkg::ST_W-1:0]) | ev;
        end else begin
            stat_q <= stat_q | ev;
        end
    end

    assign irq = |(stat_q & mask_q);

    // checks
    sequence s_read_ner;
        capture && !pwrite && paddr == umic_pkg::OFF_NER && !sc_char_err;
    endsequence

    property p_ner_clear;
        @(posedge pclk) disable iff (!presetn)
        s_read_ner |=> err_q == 8'h00 ##1 prdata == $past(err_q, 2);
    endproperty
    a_ner_clear: assert property (p_ner_clear)
        else $error("error count not cleared by read");

    property p_ner_count;
        @(posedge pclk) disable iff (!presetn)
        sc_char_err && !rd_ner && err_q != umic_pkg::ERR_MAX
            |=> err_q == $past(err_q) + 8'h01;
    endproperty
    a_ner_count: assert property (p_ner_count)
        else $error("error count did not step by one");

    property p_ner_sat;
        @(posedge pclk) disable iff (!presetn)
        err_q == umic_pkg::ERR_MAX && !rd_ner |=> err_q == umic_pkg::ERR_MAX;
    endproperty
    a_ner_sat: assert property (p_ner_sat)
        else $error("error count wrapped");

    property p_filter_hold;
        @(posedge pclk) disable iff (!presetn)
        ir_rxd != ir_filt_q && flt_cnt_q < ifilt_q |=> $stable(ir_filt_q);
    endproperty
    a_filter_hold: assert property (p_filter_hold)
        else $error("glitch passed the infrared filter");

    sequence s_hunt_ok;
        rx_frame_open == 1'b0 ##1 pre_ok;
    endsequence

    property p_pre_open;
        @(posedge pclk) disable iff (!presetn)
        s_hunt_ok |-> rx_frame_open;
    endproperty
    a_pre_open: assert property (p_pre_open)
        else $error("preamble match did not open the frame");

    property p_pre_cfg;
        @(posedge pclk) disable iff (!presetn)
        pre_ok |-> cfg_if.rx_len != 4'h0;
    endproperty
    a_pre_cfg: assert property (p_pre_cfg)
        else $error("preamble reported with detection off");

    property p_irq;
        @(posedge pclk) disable iff (!presetn)
        sc_char_err && mask_q[umic_pkg::ST_SC_ERR] |=> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt missing");

    property p_apb_wait;
        @(posedge pclk) disable iff (!presetn)
        psel && !penable ##1 access |-> !pready ##1 pready;
    endproperty
    a_apb_wait: assert property (p_apb_wait)
        else $error("apb answer not after one wait cycle");
endmodule

/* File: umic_pkg.sv */
// constants, types and coding helpers for the manchester/irda config block
package umic_pkg;

    // register byte offsets
    localparam logic [7:0]  OFF_NER     = 8'h00;
    localparam logic [7:0]  OFF_MAN     = 8'h04;
    localparam logic [7:0]  OFF_IF      = 8'h08;
    localparam logic [7:0]  OFF_STAT    = 8'h0C;
    localparam logic [7:0]  OFF_MASK    = 8'h10;

    // line config field positions
    localparam int          TXPL_LSB    = 0;
    localparam int          TXPP_LSB    = 8;
    localparam int          TXPOL_BIT   = 12;
    localparam int          RXPL_LSB    = 16;
    localparam int          RXPP_LSB    = 24;
    localparam int          RXPOL_BIT   = 28;
    localparam int          DRIFT_BIT   = 30;
    localparam logic [31:0] MAN_RW_MASK = 32'h530F_130F;

    // reset values
    localparam logic [31:0] MAN_RST     = 32'h0000_0000;
    localparam logic [7:0]  IF_RST      = 8'h00;
    localparam logic [3:0]  MASK_RST    = 4'h0;

    // status bits
    localparam int          ST_W        = 4;
    localparam int          ST_PRE_OK   = 0;
    localparam int          ST_PRE_ERR  = 1;
    localparam int          ST_SC_ERR   = 2;
    localparam int          ST_SAT      = 3;

    // 16x oversampling phase points
    localparam logic [3:0]  PH_FIRST    = 4'h4;
    localparam logic [3:0]  PH_SECOND   = 4'hC;
    localparam logic [3:0]  PH_LAST     = 4'hF;
    localparam logic [3:0]  PH_WIN_LO   = 4'h6;
    localparam logic [3:0]  PH_WIN_HI   = 4'hA;
    localparam logic [3:0]  PH_CENTER   = 4'h8;

    // smart-card error counter
    localparam logic [7:0]  ERR_MAX     = 8'hFF;

    typedef enum logic [1:0] {
        PP_ONES  = 2'b00,
        PP_ZEROS = 2'b01,
        PP_RISE  = 2'b10,
        PP_FALL  = 2'b11
    } umic_pp_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_PRE  = 2'b01,
        TX_DATA = 2'b10
    } umic_tx_st_t;

    typedef enum logic [1:0] {
        RX_OFF  = 2'b00,
        RX_HUNT = 2'b01,
        RX_SYNC = 2'b10
    } umic_rx_st_t;

    // logic value of preamble bit number idx
    function automatic logic preamble_bit(input logic [1:0] sel,
                                          input logic [3:0] idx);
        case (umic_pp_t'(sel))
            PP_ONES:  preamble_bit = 1'b1;
            PP_ZEROS: preamble_bit = 1'b0;
            PP_RISE:  preamble_bit = idx[0];
            default:  preamble_bit = ~idx[0];
        endcase
    endfunction

    // line level of the first half-bit; the second half is its inverse
    function automatic logic man_first(input logic bit_v, input logic pol);
        man_first = bit_v ^ pol;
    endfunction

endpackage

/* File: umic_man_if.sv */
// line-coding configuration shared by the encoder and decoder
`timescale 1ns/1ps
interface umic_man_if;
    logic [3:0] tx_len;
    logic [1:0] tx_sel;
    logic       tx_pol;
    logic [3:0] rx_len;
    logic [1:0] rx_sel;
    logic       rx_pol;
    logic       drift;

    modport cfg (output tx_len, tx_sel, tx_pol, rx_len, rx_sel, rx_pol,
                 drift);
    modport tx  (input tx_len, tx_sel, tx_pol);
    modport rx  (input rx_len, rx_sel, rx_pol, drift);
endinterface

/* File: umic_man_tx.sv */
// manchester encoder with programmable preamble
`timescale 1ns/1ps
module umic_man_tx (
    // clock and reset
    input  wire logic  pclk,
    input  wire logic  presetn,
    // configuration
    umic_man_if.tx     cfg,
    // core side
    input  wire logic  half_tick,
    input  wire logic  frame_req,
    input  wire logic  data_bit,
    output logic       data_take,
    // line
    output logic       txd,
    output logic       busy
);
    umic_pkg::umic_tx_st_t state_q;
    logic                  half_q;
    logic [3:0]            cnt_q;
    logic                  cur_q;
    logic                  nbit;

    always_comb begin
        nbit = (state_q == umic_pkg::TX_PRE) ?
               umic_pkg::preamble_bit(cfg.tx_sel, cnt_q) : data_bit;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= umic_pkg::TX_IDLE;
            half_q    <= 1'b0;
            cnt_q     <= 4'h0;
            cur_q     <= 1'b0;
            txd       <= 1'b1;
            data_take <= 1'b0;
        end else begin
            data_take <= 1'b0;
            if (half_tick) begin
                case (state_q)
                    umic_pkg::TX_IDLE: begin
                        txd    <= 1'b1;
                        half_q <= 1'b0;
                        cnt_q  <= 4'h0;
                        if (frame_req) begin
                            if (cfg.tx_len == 4'h0) begin
                                state_q <= umic_pkg::TX_DATA;
                            end else begin
                                state_q <= umic_pkg::TX_PRE;
                            end
                        end
                    end
                    default: begin
                        if (!half_q) begin
                            txd    <= umic_pkg::man_first(nbit,
                                                          cfg.tx_pol);
                            cur_q  <= nbit;
                            half_q <= 1'b1;
                            data_take <= (state_q == umic_pkg::TX_DATA);
                        end else begin
                            txd    <= ~umic_pkg::man_first(cur_q,
                                                           cfg.tx_pol);
                            half_q <= 1'b0;
                            if (state_q == umic_pkg::TX_PRE) begin
                                cnt_q <= cnt_q + 4'h1;
                                if (cnt_q + 4'h1 >= cfg.tx_len) begin
                                    state_q <= umic_pkg::TX_DATA;
                                end
                            end else if (!frame_req) begin
                                state_q <= umic_pkg::TX_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    assign busy = (state_q != umic_pkg::TX_IDLE);

    property p_tx_mid_flip;
        @(posedge pclk) disable iff (!presetn)
        half_tick && half_q && state_q != umic_pkg::TX_IDLE
            |=> txd != $past(txd);
    endproperty
    a_tx_mid_flip: assert property (p_tx_mid_flip)
        else $error("no mid-bit transition");

    property p_tx_no_pre;
        @(posedge pclk) disable iff (!presetn)
        half_tick && state_q == umic_pkg::TX_IDLE && frame_req
            && cfg.tx_len == 4'h0 |=> state_q == umic_pkg::TX_DATA;
    endproperty
    a_tx_no_pre: assert property (p_tx_no_pre)
        else $error("preamble sent with zero length");

    property p_tx_pre_len;
        @(posedge pclk) disable iff (!presetn)
        state_q == umic_pkg::TX_PRE |-> cnt_q < cfg.tx_len;
    endproperty
    a_tx_pre_len: assert property (p_tx_pre_len)
        else $error("preamble longer than programmed");
endmodule

/* File: umic_man_rx.sv */
// manchester decoder with preamble hunt and drift tracking
`timescale 1ns/1ps
module umic_man_rx (
    // clock and reset
    input  wire logic  pclk,
    input  wire logic  presetn,
    // configuration
    umic_man_if.rx     cfg,
    // line and control
    input  wire logic  os_tick,
    input  wire logic  rx_en,
    input  wire logic  rxd,
    // results
    output logic       bit_valid,
    output logic       bit_val,
    output logic       pre_ok,
    output logic       pre_err,
    output logic       frame_open
);
    umic_pkg::umic_rx_st_t state_q;
    logic [3:0]            ph_q;
    logic [3:0]            cnt_q;
    logic                  s1_q;
    logic                  s2_q;
    logic                  last_q;
    logic                  dec;
    logic                  edge_mid;

    assign dec      = s1_q ^ cfg.rx_pol;
    assign edge_mid = cfg.drift && (rxd != last_q)
                      && ph_q >= umic_pkg::PH_WIN_LO
                      && ph_q <= umic_pkg::PH_WIN_HI;

    // phase tracking; without drift the counter free-runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_q   <= 4'h0;
            last_q <= 1'b1;
            s1_q   <= 1'b0;
            s2_q   <= 1'b0;
        end else if (os_tick) begin
            last_q <= rxd;
            if (edge_mid) begin
                ph_q <= umic_pkg::PH_CENTER + 4'h1;
            end else begin
                ph_q <= ph_q + 4'h1;
            end
            if (ph_q == umic_pkg::PH_FIRST) begin
                s1_q <= rxd;
            end
            if (ph_q == umic_pkg::PH_SECOND) begin
                s2_q <= rxd;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= umic_pkg::RX_OFF;
            cnt_q     <= 4'h0;
            bit_valid <= 1'b0;
            bit_val   <= 1'b0;
            pre_ok    <= 1'b0;
            pre_err   <= 1'b0;
        end else begin
            bit_valid <= 1'b0;
            pre_ok    <= 1'b0;
            pre_err   <= 1'b0;
            case (state_q)
                umic_pkg::RX_OFF: begin
                    cnt_q <= 4'h0;
                    if (rx_en) begin
                        state_q <= (cfg.rx_len == 4'h0) ?
                                   umic_pkg::RX_SYNC : umic_pkg::RX_HUNT;
                    end
                end
                umic_pkg::RX_HUNT: begin
                    if (!rx_en) begin
                        state_q <= umic_pkg::RX_OFF;
                    end else if (os_tick && ph_q == umic_pkg::PH_LAST) begin
                        if (s1_q != s2_q && dec ==
                            umic_pkg::preamble_bit(cfg.rx_sel, cnt_q)) begin
                            cnt_q <= cnt_q + 4'h1;
                            if (cnt_q + 4'h1 >= cfg.rx_len) begin
                                state_q <= umic_pkg::RX_SYNC;
                                pre_ok  <= 1'b1;
                            end
                        end else begin
                            cnt_q   <= 4'h0;
                            pre_err <= 1'b1;
                        end
                    end
                end
                default: begin
                    if (!rx_en) begin
                        state_q <= umic_pkg::RX_OFF;
                    end else if (os_tick && ph_q == umic_pkg::PH_LAST
                                 && s1_q != s2_q) begin
                        bit_valid <= 1'b1;
                        bit_val   <= dec;
                    end
                end
            endcase
        end
    end

    assign frame_open = (state_q == umic_pkg::RX_SYNC);

    property p_rx_no_hunt;
        @(posedge pclk) disable iff (!presetn)
        state_q == umic_pkg::RX_OFF && rx_en && cfg.rx_len == 4'h0
            |=> state_q == umic_pkg::RX_SYNC;
    endproperty
    a_rx_no_hunt: assert property (p_rx_no_hunt)
        else $error("preamble hunt with zero length");

    property p_rx_drift;
        @(posedge pclk) disable iff (!presetn)
        os_tick && edge_mid |=> ph_q == umic_pkg::PH_CENTER + 4'h1;
    endproperty
    a_rx_drift: assert property (p_rx_drift)
        else $error("phase not realigned");

    property p_rx_free;
        @(posedge pclk) disable iff (!presetn)
        // release edge still runs the reset branch, so skip it
        presetn && os_tick && !cfg.drift |=> ph_q == $past(ph_q) + 4'h1;
    endproperty
    a_rx_free: assert property (p_rx_free)
        else $error("phase moved without drift tracking");
endmodule

/* File: umic_peer.sv */
// remote serial peer: bit timing ticks, line echo, tx line recorder
`timescale 1ns/1ps
module umic_peer (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // line
    input  wire logic        man_txd,
    input  wire logic        tx_busy,
    output logic             half_tick,
    output logic             os_tick,
    output logic             man_rxd,
    // recorded half-bits, newest in bit 0
    output logic [63:0]      hist,
    output logic [5:0]       cnt
);
    logic [2:0] div_q;
    assign os_tick   = 1'b1;
    assign half_tick = (div_q == 3'h7);
    assign man_rxd   = man_txd;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) div_q <= 3'h0;
        else div_q <= div_q + 3'h1;
    end
    // sampled at the tick, so each entry is the half just ended
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist <= 64'h0;
            cnt  <= 6'h0;
        end else if (half_tick) begin
            hist <= tx_busy ? {hist[62:0], man_txd} : 64'h0;
            cnt  <= tx_busy ? cnt + 6'h1 : 6'h0;
        end
    end
endmodule

/* File: umic_top_tb.sv */
// self-checking bench for the manchester/irda config block
`timescale 1ns/1ps
module umic_top_tb;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        sc_char_err = 0, tx_frame_req = 0, rx_enable = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, half_tick, os_tick, man_rxd;
    logic        man_txd, tx_busy, rx_frame_open, irq, b, f;
    logic [63:0] hist, e;
    logic [5:0]  cnt;
    int          fails = 0, n_tests = 0, k;
    // {preamble length, pattern, polarity}
    localparam logic [6:0] ROWS [6] = '{7'h00, 7'h30, 7'h13, 7'h24,
                                        7'h7F, 7'h09};
    always #10 pclk = ~pclk;
    umic_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sc_char_err(sc_char_err), .half_tick(half_tick),
        .tx_frame_req(tx_frame_req), .tx_data_bit(1'b1), .tx_data_take(),
        .man_txd(man_txd), .tx_busy(tx_busy), .os_tick(os_tick),
        .rx_enable(rx_enable), .ir_mode(1'b0), .man_rxd(man_rxd),
        .ir_rxd(1'b1), .rx_bit_valid(), .rx_bit(),
        .rx_frame_open(rx_frame_open), .irq(irq));
    umic_peer i_peer (.pclk(pclk), .presetn(presetn), .man_txd(man_txd),
        .tx_busy(tx_busy), .half_tick(half_tick), .os_tick(os_tick),
        .man_rxd(man_rxd), .hist(hist), .cnt(cnt));
    task automatic tally_and_finish;
        if (fails == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] g, input logic [63:0] x);
        n_tests++;
        if (g !== x) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic guard;
        if (k >= 999) begin
            fails++;
            tally_and_finish;
        end
    endtask
    // pready, read data and response all taken at the same rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 999) begin
            @(posedge pclk);
            k++;
        end
        guard;
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ROWS[r]) begin
            apb(1'b1, umic_pkg::OFF_MAN, {19'h0, ROWS[r][0], 2'h0,
                ROWS[r][2:1], 4'h0, ROWS[r][6:3]});
            e = 64'h1;
            for (int i = 0; i < int'(ROWS[r][6:3]); i++) begin
                b = ROWS[r][2] ? (ROWS[r][1] ^ i[0]) : ~ROWS[r][1];
                f = b ^ ROWS[r][0];
                e = {e[61:0], f, ~f};
            end
            f = ~ROWS[r][0];
            e = {e[61:0], f, ~f};
            @(posedge pclk);
            tx_frame_req <= 1'b1;
            k = 0;
            while (cnt !== 6'(2 * ROWS[r][6:3] + 3) && k < 999) begin
                @(negedge pclk);
                k++;
            end
            guard;
            chk(hist, e);
            @(posedge pclk);
            tx_frame_req <= 1'b0;
            k = 0;
            while (tx_busy !== 1'b0 && k < 999) begin
                @(negedge pclk);
                k++;
            end
            guard;
        end
        // second reset in mid-run, then registers and events
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, umic_pkg::OFF_MAN, 32'h0);
        chk(rd, umic_pkg::MAN_RST);
        apb(1'b1, umic_pkg::OFF_MAN, 32'hFFFF_FFFF);
        apb(1'b0, umic_pkg::OFF_MAN, 32'h0);
        chk(rd, umic_pkg::MAN_RW_MASK);
        apb(1'b0, umic_pkg::OFF_IF, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, umic_pkg::OFF_IF, 32'h0000_00A5);
        apb(1'b0, umic_pkg::OFF_IF, 32'h0);
        chk(rd, 32'h0000_00A5);
        repeat (3) @(posedge pclk) sc_char_err <= 1'b1;
        @(posedge pclk) sc_char_err <= 1'b0;
        apb(1'b0, umic_pkg::OFF_NER, 32'h0);
        chk(rd, 32'h3);
        apb(1'b0, umic_pkg::OFF_NER, 32'h0);
        chk(rd, 32'h0);
        chk(irq, 1'b0);
        apb(1'b1, umic_pkg::OFF_MASK, 32'h4);
        @(negedge pclk);
        chk(irq, 1'b1);
        repeat (300) @(posedge pclk) sc_char_err <= 1'b1;
        @(posedge pclk) sc_char_err <= 1'b0;
        apb(1'b0, umic_pkg::OFF_NER, 32'h0);
        chk(rd, 32'hFF);
        apb(1'b0, umic_pkg::OFF_STAT, 32'h0);
        chk(rd, 32'hC);
        apb(1'b1, umic_pkg::OFF_STAT, 32'hF);
        apb(1'b0, umic_pkg::OFF_STAT, 32'h0);
        chk({irq, rd}, 33'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
        // idle line while hunting: no match, mismatch status only
        apb(1'b1, umic_pkg::OFF_MAN, 32'h0001_0000);
        rx_enable <= 1'b1;
        repeat (40) @(posedge pclk);
        apb(1'b0, umic_pkg::OFF_STAT, 32'h0);
        chk({rx_frame_open, rd}, 33'h2);
        rx_enable <= 1'b0;
        apb(1'b1, umic_pkg::OFF_MAN, 32'h0);
        rx_enable <= 1'b1;
        repeat (3) @(negedge pclk);
        chk(rx_frame_open, 1'b1);
        tally_and_finish;
    end
endmodule
